// >>> rtl/fnm_map.svh
`ifndef FNM_MAP_SVH
`define FNM_MAP_SVH

// ------------------------------------------------------------
// Opcode bytes and format fields
// ------------------------------------------------------------
`define FNM_OPC_NEGATE 8'hBC
`define FNM_OPC_MUL 8'hC8
`define FNM_OPC_MUL_REGREG 8'hC9
`define FNM_OPC_EXT_MUL 8'hCA
`define FNM_OPC_EXT_MUL_REGREG 8'hCB
`define FNM_OPC_EXT_SUB 8'hBA
`define FNM_OPC_EXT_SUB_REGREG 8'hBB
`define FNM_OPC_BASED 4'h2
`define FNM_OPC_BASED_IDX 4'h4
`define FNM_BASED_SUB 2'h2
`define FNM_BASED_IDX_SUB 2'h0
`define FNM_BASED_IDX_NIB 4'hA
`define FNM_BASE_REG_FIRST 4'hC
`define FNM_BASED_DEST 4'h0

// ------------------------------------------------------------
// Total clocks per instruction form
// ------------------------------------------------------------
`define FNM_CYC_NEGATE 9'h038
`define FNM_CYC_MUL 9'h07E
`define FNM_CYC_MUL_BASED 9'h07D
`define FNM_CYC_MUL_REGREG 9'h078
`define FNM_CYC_EXT_MUL 9'h102
`define FNM_CYC_EXT_MUL_REGREG 9'h0FB
`define FNM_CYC_EXT_SUB 9'h04E
`define FNM_CYC_EXT_SUB_REGREG 9'h047

// ------------------------------------------------------------
// Number format, interrupt bits, condition codes, read and write limits
// ------------------------------------------------------------
`define FNM_EXP_MAX 10'sh07F
`define FNM_EXP_MIN 10'sh380
`define FNM_EXP_MAX8 8'h7F
`define FNM_EXP_MIN8 8'h80
`define FNM_M24_NEG1 24'h80_0000
`define FNM_M24_HALF 24'h40_0000
`define FNM_M24_MAXPOS 24'h7F_FFFF
`define FNM_M40_NEG1 40'h80_0000_0000
`define FNM_M40_HALF 40'h40_0000_0000
`define FNM_M40_MAXPOS 40'h7F_FFFF_FFFF
`define FNM_PI_OVF_BIT 3
`define FNM_PI_UNF_BIT 6
`define FNM_CS_ZERO 4'h2
`define FNM_CS_NEG 4'h1
`define FNM_CS_POS 4'h4
`define FNM_READ_LAST 3'h6
`define FNM_WRITE_LAST_SGL 2'h1
`define FNM_WRITE_LAST_EXT 2'h2

`endif

// >>> rtl/fnm_pkg.sv
package fnm_pkg;
	typedef enum logic [3:0] {
		OP_NEG,
		OP_MUL,
		OP_MUL_BASED,
		OP_MUL_BASED_IDX,
		OP_MUL_REGREG,
		OP_EXT_MUL,
		OP_EXT_MUL_REGREG,
		OP_EXT_SUB,
		OP_EXT_SUB_REGREG
	} fnm_op_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_CALC,
		ST_WRITE,
		ST_HOLD
	} fnm_state_type;
endpackage

// >>> rtl/fnm_regfile.sv
`timescale 1ns/100ps
module fnm_regfile #(
	parameter int AW = 4,
	parameter int DW = 16
) (
	input wire logic clk_sys_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Read data registered; old word returned on same-address write
	always_ff @(posedge clk_sys_i) begin
		if (ce_i) begin
			if (we_i) begin
				mem[waddr_i] <= wdata_i;
			end
			rdata_o <= mem[raddr_i];
		end
	end
endmodule

// >>> rtl/fnm_norm.sv
`timescale 1ns/100ps
module fnm_norm #(
	parameter int W = 40,
	parameter int EW = 10
) (
	input wire logic [W-1:0] mant_i,
	input wire logic signed [EW-1:0] exp_i,
	output logic [W-1:0] mant_o,
	output logic signed [EW-1:0] exp_o,
	output logic zero_o
);
	localparam int SW = $clog2(W);
	logic [SW-1:0] sh;
	logic hit;

	// Count redundant sign bits below the sign
	always_comb begin
		sh = '0;
		hit = 1'b0;
		for (int i = W - 2; i >= 0; i--) begin
			if (!hit && (mant_i[i] != mant_i[W-1])) begin
				sh = SW'(W - 2 - i);
				hit = 1'b1;
			end
		end
		if (!hit && mant_i[W-1]) begin
			sh = SW'(W - 1);
		end
	end

	assign zero_o = (mant_i == '0);
	assign mant_o = mant_i << sh;
	assign exp_o = exp_i - EW'(sh);
endmodule

// >>> rtl/fnm_unit.sv
// Functional notes
// - Extended subtract aligns operand right by exponent difference when accumulator is nonzero.
// - Mantissa overflow shifts right one, flips sign back, bumps exponent.
// - Extended subtract exponent overflow raises bit 3, saturates by sign, stops.
// - Extended subtract underflow after normalising raises bit 6, result zero.
// - Extended values hold 39-bit mantissa plus sign over three registers.
// - Negate complements 24-bit mantissa, keeps exponent, writes destination pair.
// - Destination may equal source; all reads finish before any write.
// - Negating zero gives zero.
// - Positive half mantissa negates to minus one, exponent minus one.
// - Minus one mantissa negates to positive half, exponent plus one.
// - Minus one at exponent 127 negates to overflow, bit 3, saturation.
// - Half at exponent -128 negates to underflow, bit 6, zero.
// - Condition status from written result: zero, negative or positive code.
// - Negate opcode byte BC, two register fields, 56 clocks.
// - Multiply adds exponents first; sum above maximum overflows, no product.
// - Multiply exponent sum below minimum raises bit 6, result zero.
// - Multiply overflow raises bit 3, saturates positive if signs match.
// - Multiply mantissas, shift product left one, normalise, keep upper bits.
// - Minus one times minus one gives half, exponent plus one, may overflow.
// - Product normalisation underflow raises bit 6, result zero.
// - Multiply takes 126, 125 based, 120 register form clocks.
// - Extended multiply uses same checks on three-register operands.
// - Extended multiply opcode CB 251 clocks, memory form CA 258 clocks.
`timescale 1ns/100ps
`include "fnm_map.svh"
module fnm_unit (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [15:0] instr_i,
	input wire logic [47:0] derived_op_i,
	input wire logic host_we_i,
	input wire logic [3:0] host_addr_i,
	input wire logic [15:0] host_wdata_i,
	output logic [15:0] host_rdata_o,
	output logic busy_o,
	output logic done_o,
	output logic rejected_o,
	output logic [3:0] cond_status_o,
	output logic [15:0] pending_irq_word_set_o,
	output logic [3:0] base_reg_sel_o
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta, rst_n;
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------
	wire [7:0] opc = instr_i[15:8];
	wire dec_neg = (opc == `FNM_OPC_NEGATE);
	wire dec_mul = (opc == `FNM_OPC_MUL);
	wire dec_mulr = (opc == `FNM_OPC_MUL_REGREG);
	wire dec_emul = (opc == `FNM_OPC_EXT_MUL);
	wire dec_emulr = (opc == `FNM_OPC_EXT_MUL_REGREG);
	wire dec_esub = (opc == `FNM_OPC_EXT_SUB);
	wire dec_esubr = (opc == `FNM_OPC_EXT_SUB_REGREG);
	wire dec_mb = (instr_i[15:12] == `FNM_OPC_BASED) && (instr_i[11:10] == `FNM_BASED_SUB);
	wire dec_mbx = (instr_i[15:12] == `FNM_OPC_BASED_IDX)
		&& (instr_i[11:10] == `FNM_BASED_IDX_SUB) && (instr_i[7:4] == `FNM_BASED_IDX_NIB);
	wire dec_based = dec_mb | dec_mbx;
	wire dec_valid = dec_neg | dec_mul | dec_mulr | dec_emul | dec_emulr
		| dec_esub | dec_esubr | dec_based;
	wire fnm_pkg::fnm_op_type dec_op = dec_neg ? fnm_pkg::OP_NEG :
		dec_mul ? fnm_pkg::OP_MUL :
		dec_mb ? fnm_pkg::OP_MUL_BASED :
		dec_mbx ? fnm_pkg::OP_MUL_BASED_IDX :
		dec_mulr ? fnm_pkg::OP_MUL_REGREG :
		dec_emul ? fnm_pkg::OP_EXT_MUL :
		dec_emulr ? fnm_pkg::OP_EXT_MUL_REGREG :
		dec_esub ? fnm_pkg::OP_EXT_SUB : fnm_pkg::OP_EXT_SUB_REGREG;
	wire [8:0] dec_cyc = dec_neg ? `FNM_CYC_NEGATE :
		dec_mul ? `FNM_CYC_MUL :
		dec_based ? `FNM_CYC_MUL_BASED :
		dec_mulr ? `FNM_CYC_MUL_REGREG :
		dec_emul ? `FNM_CYC_EXT_MUL :
		dec_emulr ? `FNM_CYC_EXT_MUL_REGREG :
		dec_esub ? `FNM_CYC_EXT_SUB : `FNM_CYC_EXT_SUB_REGREG;
	wire [3:0] dec_dest = dec_based ? `FNM_BASED_DEST : instr_i[7:4];
	wire [3:0] dec_base = `FNM_BASE_REG_FIRST + {2'b00, instr_i[9:8]};

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	fnm_pkg::fnm_state_type st;
	fnm_pkg::fnm_op_type op;
	logic [3:0] dest_reg_first, source_reg_first;
	logic [47:0] do_q;
	logic [8:0] cyc, cyc_last;
	logic [2:0] idx;
	logic [15:0] w [0:5];
	logic [39:0] res_m;
	logic [7:0] res_e;
	logic res_ovf, res_unf;
	logic [3:0] res_cs;

	wire is_neg = (op == fnm_pkg::OP_NEG);
	wire is_sub = (op == fnm_pkg::OP_EXT_SUB) || (op == fnm_pkg::OP_EXT_SUB_REGREG);
	wire is_ext = is_sub || (op == fnm_pkg::OP_EXT_MUL) || (op == fnm_pkg::OP_EXT_MUL_REGREG);
	wire src_reg = is_neg || (op == fnm_pkg::OP_MUL_REGREG)
		|| (op == fnm_pkg::OP_EXT_MUL_REGREG) || (op == fnm_pkg::OP_EXT_SUB_REGREG);
	wire [1:0] wr_last = is_ext ? `FNM_WRITE_LAST_EXT : `FNM_WRITE_LAST_SGL;

	// ------------------------------------------------------------
	// Register file access
	// ------------------------------------------------------------
	// Reads of both triples finish before the first write, so the two may overlap
	wire [3:0] rd_addr = (idx < 3'h3) ? (dest_reg_first + 4'(idx)) :
		(source_reg_first + 4'(idx - 3'h3));
	wire [3:0] rf_raddr = (st == fnm_pkg::ST_READ) ? rd_addr : host_addr_i;
	wire rf_we_int = (st == fnm_pkg::ST_WRITE);
	wire rf_we = rf_we_int || ((st == fnm_pkg::ST_IDLE) && host_we_i);
	wire [3:0] rf_waddr = rf_we_int ? (dest_reg_first + 4'(idx)) : host_addr_i;
	wire [15:0] wr_word = (idx == 3'h0) ? res_m[39:24] :
		(idx == 3'h1) ? {res_m[23:16], res_e} : res_m[15:0];
	wire [15:0] rf_wdata = rf_we_int ? wr_word : host_wdata_i;
	wire [15:0] rf_rdata;

	fnm_regfile #(
		.AW(4),
		.DW(16)
	) u_regfile (
		.clk_sys_i(clk_sys_i),
		.ce_i(ce_i),
		.we_i(rf_we),
		.waddr_i(rf_waddr),
		.wdata_i(rf_wdata),
		.raddr_i(rf_raddr),
		.rdata_o(rf_rdata)
	);

	// ------------------------------------------------------------
	// Operand unpacking
	// ------------------------------------------------------------
	wire [15:0] s0 = src_reg ? w[3] : do_q[47:32];
	wire [15:0] s1 = src_reg ? w[4] : do_q[31:16];
	wire [15:0] s2 = src_reg ? w[5] : do_q[15:0];
	wire [15:0] a2 = is_ext ? w[2] : 16'h0000;
	wire [15:0] o2 = is_ext ? s2 : 16'h0000;
	wire signed [39:0] acc_fraction = {w[0], w[1][15:8], a2};
	wire signed [39:0] operand_fraction = {s0, s1[15:8], o2};
	wire signed [9:0] acc_exponent = {{2{w[1][7]}}, w[1][7:0]};
	wire signed [9:0] operand_exponent = {{2{s1[7]}}, s1[7:0]};

	// ------------------------------------------------------------
	// Negate
	// ------------------------------------------------------------
	wire [23:0] m24 = operand_fraction[39:16];
	wire n_is_neg1 = (m24 == `FNM_M24_NEG1);
	wire n_is_half = (m24 == `FNM_M24_HALF);
	wire neg_ovf = n_is_neg1 && (s1[7:0] == `FNM_EXP_MAX8);
	wire neg_unf = n_is_half && (s1[7:0] == `FNM_EXP_MIN8);
	wire [23:0] neg_m = neg_ovf ? `FNM_M24_MAXPOS :
		neg_unf ? 24'h00_0000 :
		n_is_neg1 ? `FNM_M24_HALF :
		n_is_half ? `FNM_M24_NEG1 :
		(24'h00_0000 - m24);
	wire [7:0] neg_e = neg_ovf ? `FNM_EXP_MAX8 :
		neg_unf ? 8'h00 :
		n_is_neg1 ? (s1[7:0] + 8'h01) :
		n_is_half ? (s1[7:0] - 8'h01) : s1[7:0];

	// ------------------------------------------------------------
	// Multiply
	// ------------------------------------------------------------
	wire signed [9:0] n_mul = acc_exponent + operand_exponent;
	wire mul_pre_ovf = (n_mul > `FNM_EXP_MAX);
	wire mul_pre_unf = (n_mul < `FNM_EXP_MIN);
	wire signed [79:0] prod = acc_fraction * operand_fraction;
	wire [79:0] prod2 = prod << 1;
	wire [39:0] product_fraction = is_ext ? prod2[79:40] : {prod2[79:56], 16'h0000};
	wire prod_neg1 = (product_fraction == `FNM_M40_NEG1);
	wire signed [9:0] n_mul1 = prod_neg1 ? (n_mul + 10'sh001) : n_mul;
	wire [39:0] prod_adj = prod_neg1 ? `FNM_M40_HALF : product_fraction;
	wire mul_post_ovf = (n_mul1 > `FNM_EXP_MAX);
	wire [39:0] mnm_m;
	wire signed [9:0] mnm_e;
	wire mnm_zero;

	fnm_norm #(
		.W(40),
		.EW(10)
	) u_norm_mul (
		.mant_i(prod_adj),
		.exp_i(n_mul1),
		.mant_o(mnm_m),
		.exp_o(mnm_e),
		.zero_o(mnm_zero)
	);

	wire mul_ovf = mul_pre_ovf || (!mul_pre_unf && mul_post_ovf);
	// Sign of the saturated value comes from the operands on exponent-sum overflow, otherwise from the adjusted product
	wire mul_sat_neg = mul_pre_ovf ? (acc_fraction[39] ^ operand_fraction[39]) :
		prod_adj[39];
	wire mul_unf = !mul_ovf && (mul_pre_unf || (!mnm_zero && (mnm_e < `FNM_EXP_MIN)));

	// ------------------------------------------------------------
	// Extended subtract
	// ------------------------------------------------------------
	wire signed [9:0] n_sub = acc_exponent - operand_exponent;
	wire signed [9:0] n_neg = 10'sh000 - n_sub;
	wire acc_zero = (acc_fraction == '0);
	wire opd_zero = (operand_fraction == '0);
	wire align_o = (n_sub > 10'sh000) && !acc_zero;
	wire align_a = (n_sub < 10'sh000) && !opd_zero;
	wire signed [39:0] opd_al = align_o ? (operand_fraction >>> n_sub[8:0]) :
		operand_fraction;
	wire signed [39:0] acc_al = align_a ? (acc_fraction >>> n_neg[8:0]) : acc_fraction;
	wire signed [9:0] e0 = (acc_zero || align_a) ? operand_exponent : acc_exponent;
	wire [40:0] diff = {acc_al[39], acc_al} - {opd_al[39], opd_al};
	wire mantissa_carry_out = diff[40] ^ diff[39];
	// Taking the 41-bit difference is the one-place shift with the sign put back
	wire [39:0] dm = mantissa_carry_out ? diff[40:1] : diff[39:0];
	wire signed [9:0] e1 = mantissa_carry_out ? (e0 + 10'sh001) : e0;
	wire sub_ovf = (e1 > `FNM_EXP_MAX);
	wire [39:0] snm_m;
	wire signed [9:0] snm_e;
	wire snm_zero;

	fnm_norm #(
		.W(40),
		.EW(10)
	) u_norm_sub (
		.mant_i(dm),
		.exp_i(e1),
		.mant_o(snm_m),
		.exp_o(snm_e),
		.zero_o(snm_zero)
	);

	wire sub_unf = !sub_ovf && !snm_zero && (snm_e < `FNM_EXP_MIN);

	// ------------------------------------------------------------
	// Result selection
	// ------------------------------------------------------------
	wire c_ovf = is_neg ? neg_ovf : is_sub ? sub_ovf : mul_ovf;
	wire c_unf = is_neg ? neg_unf : is_sub ? sub_unf : mul_unf;
	wire c_sat_neg = is_sub ? dm[39] : mul_sat_neg;
	wire [39:0] c_sat = c_sat_neg ? `FNM_M40_NEG1 : `FNM_M40_MAXPOS;
	wire c_zero = is_sub ? snm_zero : mnm_zero;
	wire [39:0] c_nm = is_sub ? snm_m : mnm_m;
	wire [7:0] c_ne = is_sub ? snm_e[7:0] : mnm_e[7:0];
	wire [39:0] c_m_raw = is_neg ? {neg_m, 16'h0000} :
		c_ovf ? c_sat :
		(c_unf || c_zero) ? 40'h00_0000_0000 : c_nm;
	wire [39:0] calc_m = is_ext ? c_m_raw : {c_m_raw[39:16], 16'h0000};
	wire [7:0] calc_e = is_neg ? neg_e :
		c_ovf ? `FNM_EXP_MAX8 :
		(c_unf || c_zero) ? 8'h00 : c_ne;
	wire [3:0] calc_cs = (calc_m == '0) ? `FNM_CS_ZERO :
		calc_m[39] ? `FNM_CS_NEG : `FNM_CS_POS;
	wire [15:0] irq_set = (16'(res_ovf) << `FNM_PI_OVF_BIT)
		| (16'(res_unf) << `FNM_PI_UNF_BIT);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	wire finish = (st == fnm_pkg::ST_HOLD) && (cyc == cyc_last);

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			st <= fnm_pkg::ST_IDLE;
			op <= fnm_pkg::OP_NEG;
			dest_reg_first <= 4'h0;
			source_reg_first <= 4'h0;
			do_q <= 48'h0000_0000_0000;
			cyc <= 9'h000;
			cyc_last <= 9'h000;
			idx <= 3'h0;
		end else if (ce_i) begin
			cyc <= cyc + 9'h001;
			unique case (st)
				fnm_pkg::ST_IDLE: begin
					cyc <= 9'h000;
					idx <= 3'h0;
					if (start_i && dec_valid) begin
						st <= fnm_pkg::ST_READ;
						op <= dec_op;
						dest_reg_first <= dec_dest;
						source_reg_first <= instr_i[3:0];
						do_q <= derived_op_i;
						cyc <= 9'h001;
						cyc_last <= dec_cyc - 9'h001;
					end
				end
				fnm_pkg::ST_READ: begin
					idx <= idx + 3'h1;
					if (idx == `FNM_READ_LAST) begin
						st <= fnm_pkg::ST_CALC;
					end
				end
				fnm_pkg::ST_CALC: begin
					idx <= 3'h0;
					st <= fnm_pkg::ST_WRITE;
				end
				fnm_pkg::ST_WRITE: begin
					idx <= idx + 3'h1;
					if (idx[1:0] == wr_last) begin
						st <= fnm_pkg::ST_HOLD;
					end
				end
				fnm_pkg::ST_HOLD: begin
					if (finish) begin
						st <= fnm_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Captured read data lags its address by one cycle
	always_ff @(posedge clk_sys_i) begin
		if (ce_i && (st == fnm_pkg::ST_READ) && (idx != 3'h0)) begin
			w[idx - 3'h1] <= rf_rdata;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			res_m <= 40'h00_0000_0000;
			res_e <= 8'h00;
			res_ovf <= 1'b0;
			res_unf <= 1'b0;
			res_cs <= 4'h0;
		end else if (ce_i && (st == fnm_pkg::ST_CALC)) begin
			res_m <= calc_m;
			res_e <= calc_e;
			res_ovf <= c_ovf;
			res_unf <= c_unf;
			res_cs <= calc_cs;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			host_rdata_o <= 16'h0000;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			rejected_o <= 1'b0;
			cond_status_o <= 4'h0;
			pending_irq_word_set_o <= 16'h0000;
			base_reg_sel_o <= 4'h0;
		end else if (ce_i) begin
			host_rdata_o <= rf_rdata;
			busy_o <= (st == fnm_pkg::ST_IDLE) ? (start_i && dec_valid) : !finish;
			done_o <= finish;
			rejected_o <= start_i && ((st != fnm_pkg::ST_IDLE) || !dec_valid);
			pending_irq_word_set_o <= finish ? irq_set : 16'h0000;
			if (finish) begin
				cond_status_o <= res_cs;
			end
			if ((st == fnm_pkg::ST_IDLE) && start_i && dec_based) begin
				base_reg_sel_o <= dec_base;
			end
		end
	end
endmodule

// >>> dv/fnm_seq_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Instruction sequencer stand-in
// ------------------------------------------------------------
module fnm_seq_model (
	input wire logic clk_sys_i,
	output logic start_o,
	output logic [15:0] instr_o,
	output logic [47:0] derived_op_o
);
	initial begin
		start_o = 1'b0;
		instr_o = 16'h0000;
		derived_op_o = 48'h0000_0000_0000;
	end

	// One-cycle request; fields scrambled afterwards so stale values never pass
	task automatic issue(logic [15:0] ins, logic [47:0] op);
		@(posedge clk_sys_i);
		#1;
		start_o = 1'b1;
		instr_o = ins;
		derived_op_o = op;
		@(posedge clk_sys_i);
		#1;
		start_o = 1'b0;
		instr_o = ~ins;
		derived_op_o = ~op;
	endtask
endmodule

// >>> dv/fnm_unit_sva.sv
`timescale 1ns/100ps
module fnm_unit_sva (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [15:0] instr_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic [3:0] cond_status_o,
	input wire logic [15:0] pending_irq_word_set_o,
	input wire logic [3:0] base_reg_sel_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	// ------------------------------------------------------------
	// Accepted request decode
	// ------------------------------------------------------------
	wire take = ce_i && start_i && !busy_o;
	wire [7:0] opc = instr_i[15:8];
	wire based = (instr_i[15:12] == 4'h2 && instr_i[11:10] == 2'b10) ||
		(instr_i[15:12] == 4'h4 && instr_i[11:10] == 2'b00 && instr_i[7:4] == 4'hA);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_neg_clocks: assert property (take && opc == 8'hBC |=> busy_o[*8] ##48 done_o)
		else $error("negate did not finish in 56 clocks");
	a_mul_clocks: assert property (take && opc == 8'hC9 |-> ##120 done_o)
		else $error("register multiply did not finish in 120 clocks");
	a_direct_clocks: assert property (take && opc == 8'hC8 |-> ##126 done_o)
		else $error("direct multiply did not finish in 126 clocks");
	a_based_clocks: assert property (take && based |-> ##125 done_o)
		else $error("based multiply did not finish in 125 clocks");
	a_xmul_clocks: assert property (take && opc == 8'hCB |-> ##251 done_o)
		else $error("extended register multiply did not finish in 251 clocks");
	a_xmem_clocks: assert property (take && opc == 8'hCA |-> ##258 done_o)
		else $error("extended memory multiply did not finish in 258 clocks");
	a_base_select: assert property (take && based |=>
		base_reg_sel_o == {2'b11, $past(instr_i[9:8])})
		else $error("base register selection wrong");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done held longer than one cycle");
	a_irq_bits: assert property (pending_irq_word_set_o != 16'h0000 |->
		done_o && (pending_irq_word_set_o & 16'hFFB7) == 16'h0000)
		else $error("pending interrupt pulse outside done or on a wrong bit");
	a_cs_code: assert property (done_o |-> cond_status_o inside {4'h1, 4'h2, 4'h4})
		else $error("condition status code illegal");
	a_cs_hold: assert property ($changed(cond_status_o) |-> done_o)
		else $error("condition status changed without done");
	a_unf_zero: assert property (done_o && pending_irq_word_set_o[6] |->
		cond_status_o == 4'h2)
		else $error("underflow result not zero");
	a_ovf_nonzero: assert property (done_o && pending_irq_word_set_o[3] |->
		cond_status_o != 4'h2)
		else $error("overflow result reported zero");

	c_ovf: cover property (done_o && pending_irq_word_set_o[3]);
	c_unf: cover property (done_o && pending_irq_word_set_o[6]);
	c_busy_req: cover property (start_i && busy_o);
endmodule

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ce_i = 1'b1;
	logic host_we_i = 1'b0;
	logic [3:0] host_addr_i = 4'h0;
	logic [15:0] host_wdata_i = 16'h0000;
	logic start_i;
	logic [15:0] instr_i;
	logic [47:0] derived_op_i;
	logic [15:0] host_rdata_o;
	logic [15:0] pending_irq_word_set_o;
	logic [3:0] cond_status_o;
	logic [3:0] base_reg_sel_o;
	logic busy_o;
	logic done_o;
	logic rejected_o;
	logic [28:0] expq[$];
	logic [31:0] seed = 32'h0000_004D;
	int miscompares = 0;
	int checks = 0;
	int cnt = 0;
	int rejects = 0;

	always #2.5 clk_sys_i = ~clk_sys_i;

	fnm_unit dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .start_i(start_i),
		.instr_i(instr_i), .derived_op_i(derived_op_i), .host_we_i(host_we_i),
		.host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
		.busy_o(busy_o), .done_o(done_o), .rejected_o(rejected_o),
		.cond_status_o(cond_status_o), .pending_irq_word_set_o(pending_irq_word_set_o),
		.base_reg_sel_o(base_reg_sel_o));
	fnm_seq_model seq (.clk_sys_i(clk_sys_i), .start_o(start_i), .instr_o(instr_i),
		.derived_op_o(derived_op_i));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xorshift(logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Saturated maximum is the only mantissa used with low bits set
	function automatic logic [39:0] wide(logic [15:0] h);
		return {h, (h == 16'h7FFF) ? 24'hFF_FFFF : 24'h00_0000};
	endfunction

	task automatic check(string what, logic [47:0] exp, logic [47:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk_sys_i);
		#1;
		host_we_i = 1'b1;
		host_addr_i = a;
		host_wdata_i = d;
		@(posedge clk_sys_i);
		#1;
		host_we_i = 1'b0;
		host_wdata_i = ~d;
	endtask

	task automatic ld(logic [3:0] a, logic [39:0] m, logic [7:0] e, logic ext);
		wr(a, m[39:24]);
		wr(a + 4'h1, {m[23:16], e});
		if (ext) wr(a + 4'h2, m[15:0]);
	endtask

	task automatic rd(logic [3:0] a, logic [15:0] e);
		@(posedge clk_sys_i);
		#1;
		host_addr_i = a;
		repeat (3) @(posedge clk_sys_i);
		#1;
		check("host_rdata_o", {32'h0000_0000, e}, {32'h0000_0000, host_rdata_o});
	endtask

	task automatic wait_done();
		for (int i = 0; i < 300 && done_o !== 1'b1; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		if (done_o !== 1'b1) miscompares++;
		@(posedge clk_sys_i);
	endtask

	// Loads the destination and, for register forms, the source, runs one instruction, reads the destination back
	task automatic t(logic [15:0] ins, logic [15:0] ah, logic [7:0] ae, logic [15:0] bh,
			logic [7:0] be, logic [15:0] xh, logic [7:0] xe, logic [3:0] cs,
			logic [15:0] irq, logic [8:0] cyc);
		logic [39:0] b;
		logic [39:0] x;
		logic ext;
		logic [3:0] d;
		b = wide(bh);
		x = wide(xh);
		ext = (ins[15:9] == 7'h65) || (ins[15:9] == 7'h5D);
		d = (ins[15:12] == 4'h2 || ins[15:12] == 4'h4) ? 4'h0 : ins[7:4];
		ld(d, wide(ah), ae, ext);
		if (ins[15:8] inside {8'hBC, 8'hC9, 8'hCB, 8'hBB}) ld(ins[3:0], b, be, ext);
		expq.push_back({cs, irq, cyc});
		seq.issue(ins, {b[39:24], b[23:16], be, b[15:0]});
		wait_done();
		rd(d, x[39:24]);
		rd(d + 4'h1, {x[23:16], xe});
		if (ext) rd(d + 4'h2, x[15:0]);
	endtask

	// ------------------------------------------------------------
	// Result monitor
	// ------------------------------------------------------------
	always @(posedge clk_sys_i) begin
		logic [28:0] e;
		if (done_o === 1'b1) begin
			e = expq.pop_front();
			check("done_o latency", e[8:0], cnt[8:0] + 9'h001);
			check("cond_status_o", e[28:25], cond_status_o);
			check("pending_irq_word_set_o", e[24:9], pending_irq_word_set_o);
		end
		if (start_i && !busy_o) cnt = 0;
		else cnt++;
		if (rejected_o === 1'b1) rejects++;
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		logic [15:0] h;
		repeat (3) @(posedge clk_sys_i);
		#1;
		rstn_i = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		t(16'hBC22, 16'h0000, 8'h00, 16'h6000, 8'h05, 16'hA000, 8'h05, 4'h1, 16'h0000, 9'h038);
		t(16'hBC42, 16'h0000, 8'h00, 16'h0000, 8'h00, 16'h0000, 8'h00, 4'h2, 16'h0000, 9'h038);
		t(16'hBC42, 16'h0000, 8'h00, 16'h4000, 8'h03, 16'h8000, 8'h02, 4'h1, 16'h0000, 9'h038);
		t(16'hBC22, 16'h0000, 8'h00, 16'h8000, 8'h03, 16'h4000, 8'h04, 4'h4, 16'h0000, 9'h038);
		t(16'hBC42, 16'h0000, 8'h00, 16'h8000, 8'h7F, 16'h7FFF, 8'h7F, 4'h4, 16'h0008, 9'h038);
		t(16'hBC42, 16'h0000, 8'h00, 16'h4000, 8'h80, 16'h0000, 8'h00, 4'h2, 16'h0040, 9'h038);
		for (int i = 0; i < 3; i++) begin
			seed = xorshift(seed);
			h = {2'b01, seed[13:1], 1'b1};
			t(16'hBC42, 16'h0000, 8'h00, h, seed[31:24], 16'h0000 - h, seed[31:24], 4'h1,
				16'h0000, 9'h038);
		end
		t(16'hC902, 16'h4000, 8'h01, 16'h4000, 8'h01, 16'h4000, 8'h01, 4'h4, 16'h0000, 9'h078);
		t(16'hC902, 16'h8000, 8'h01, 16'h8000, 8'h02, 16'h4000, 8'h04, 4'h4, 16'h0000, 9'h078);
		t(16'hC902, 16'h4000, 8'h40, 16'h4000, 8'h40, 16'h7FFF, 8'h7F, 4'h4, 16'h0008, 9'h078);
		t(16'hC902, 16'h4000, 8'h40, 16'h8000, 8'h40, 16'h8000, 8'h7F, 4'h1, 16'h0008, 9'h078);
		t(16'hC902, 16'h4000, 8'h80, 16'h4000, 8'hFF, 16'h0000, 8'h00, 4'h2, 16'h0040, 9'h078);
		t(16'hC902, 16'h8000, 8'h40, 16'h8000, 8'h3F, 16'h7FFF, 8'h7F, 4'h4, 16'h0008, 9'h078);
		t(16'hC902, 16'h4000, 8'h80, 16'h4000, 8'h00, 16'h0000, 8'h00, 4'h2, 16'h0040, 9'h078);
		t(16'hC800, 16'h4000, 8'h01, 16'h4000, 8'h01, 16'h4000, 8'h01, 4'h4, 16'h0000, 9'h07E);
		t(16'h2B05, 16'h4000, 8'h01, 16'h4000, 8'h01, 16'h4000, 8'h01, 4'h4, 16'h0000, 9'h07D);
		t(16'h43A0, 16'h4000, 8'h01, 16'h4000, 8'h01, 16'h4000, 8'h01, 4'h4, 16'h0000, 9'h07D);
		t(16'hCB04, 16'h8000, 8'h01, 16'h8000, 8'h01, 16'h4000, 8'h03, 4'h4, 16'h0000, 9'h0FB);
		t(16'hCA00, 16'h4000, 8'h40, 16'h8000, 8'h40, 16'h8000, 8'h7F, 4'h1, 16'h0008, 9'h102);
		t(16'hBB04, 16'h4000, 8'h02, 16'h4000, 8'h01, 16'h4000, 8'h01, 4'h4, 16'h0000, 9'h047);
		t(16'hBB04, 16'h4000, 8'h7F, 16'h8000, 8'h7F, 16'h7FFF, 8'h7F, 4'h4, 16'h0008, 9'h047);
		t(16'hBB04, 16'h6000, 8'h80, 16'h4000, 8'h80, 16'h0000, 8'h00, 4'h2, 16'h0040, 9'h047);
		// Request while busy and an undecodable one are both refused
		ld(4'h2, wide(16'h6000), 8'h05, 1'b0);
		expq.push_back({4'h1, 16'h0000, 9'h038});
		seq.issue(16'hBC42, 48'h0000_0000_0000);
		seq.issue(16'hC942, 48'h0000_0000_0000);
		wait_done();
		seq.issue(16'h0000, 48'h0000_0000_0000);
		repeat (2) @(posedge clk_sys_i);
		check("rejected_o count", 48'h0000_0000_0002, rejects);
		rd(4'h4, 16'hA000);
		check("results outstanding", 48'h0000_0000_0000, expq.size());
		conclude();
	end

	// Generous margin over the longest expected run
	initial begin
		#100000;
		miscompares++;
		conclude();
	end
endmodule

bind fnm_unit fnm_unit_sva chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
	.start_i(start_i), .instr_i(instr_i), .busy_o(busy_o), .done_o(done_o),
	.cond_status_o(cond_status_o), .pending_irq_word_set_o(pending_irq_word_set_o),
	.base_reg_sel_o(base_reg_sel_o));
